// File: common/sfc_pkg.sv
/*
 * sfc_pkg: opcodes, status bit layout, phase states, pin bundles and timing
 * for the serial flash command sequencer.
 * assumes one system clock; pins are already synchronous to it.
 */
package sfc_pkg;
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_FAST  = 8'h0B;
    localparam logic [7:0] OP_DUAL  = 8'h3B;
    localparam int BIT_BUSY    = 0;
    localparam int BIT_WRLATCH = 1;
    localparam int BIT_STLOCK  = 8;
    localparam int BIT_LOCK0   = 10;
    localparam int BIT_LOCK3   = 13;
    localparam int BIT_SUSPEND = 15;
    localparam logic [15:0] SR1_WR_MASK = 16'h00FC;
    localparam logic [15:0] SR2_WR_MASK = 16'h7F00;
    localparam logic [4:0] OPCODE_BITS = 5'h08;
    localparam logic [4:0] ADDR_BITS   = 5'h18;
    localparam logic [4:0] DUMMY_BITS  = 5'h08;
    localparam logic [4:0] WORD_BITS   = 5'h10;
    localparam int CLK_PERIOD_NS         = 5;
    localparam int STATUS_WRITE_TIME_NS  = 15_000_000;
    localparam int STATUS_WRITE_CYCLES   = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
    typedef enum logic [7:0] {
        ST_CMD  = 8'h01,
        ST_DONE = 8'h02,
        ST_ADDR = 8'h04,
        ST_DUMY = 8'h08,
        ST_DATA = 8'h10,
        ST_STAT = 8'h20,
        ST_WRSR = 8'h40,
        ST_IGN  = 8'h80
    } sfc_state_t;
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } sfc_pins_in_t;
    typedef struct packed {
        logic first_io_line;
        logic first_io_line_oe;
        logic second_io_line;
        logic second_io_line_oe;
    } sfc_pins_out_t;
endpackage : sfc_pkg

// File: hdl/sfc_core.sv
/*
 * sfc_core: instruction decoder and sequencer of a serial flash: write
 * enables, status read/write, read, fast read and dual output read.
 * assumes serial clock at most a quarter of clk_sys_i, array data valid one
 * cycle after mem_addr_o, and an outside model holding the stored status.
 */
// Summary of operation
// - opcode 06h sets write enable latch
// - opcode 50h arms next volatile status write
// - opcode 04h clears write enable latch
// - latch cleared at power-up and completions
// - opcode 04h also cancels volatile arm
// - 05h/35h shift status out MSB first
// - status readable anytime, repeats until deselect
// - only bits 7..2 and 14..8 writable
// - security lock bits never return to 0 in the stored copy
// - stored write needs latch set beforehand
// - armed write updates volatile copy, latch 0
// - volatile write keeps lock bits 8 and 13..11 set, not bit 10
// - power-on reloads status from stored copy
// - deselect only after 8 or 16 bits
// - eight bits of 01h leave register 2
// - stored write busy for WRITE_CYCLES clocks, then clear
// - volatile write applies promptly, busy stays 0
// - 03h: opcode, 24-bit address, data MSB first
// - address increments, stream until deselect
// - read ignored while busy
// - 0Bh adds eight dummy clocks
// - 3Bh outputs two bits per clock
// - odd bits on line two, even on one
`timescale 1ns/1ps
module sfc_core #(
    parameter int WRITE_CYCLES = sfc_pkg::STATUS_WRITE_CYCLES
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   nrst_i,
    input  wire sfc_pkg::sfc_pins_in_t  pins_i,
    output sfc_pkg::sfc_pins_out_t      pins_o,
    output logic [23:0]                 mem_addr_o,
    input  wire logic [7:0]             mem_data_i,
    input  wire logic                   ext_busy_i,
    input  wire logic                   latch_clear_i,
    input  wire logic                   suspend_flag_i,
    input  wire logic [15:0]            nv_status_i,
    output logic [15:0]                 nv_status_o,
    output logic [7:0]                  status_register_low_o,
    output logic [7:0]                  status_register_high_o
);
    import sfc_pkg::*;

    sfc_state_t  state_q;
    logic        sclk_q, cs_n_q;
    logic [4:0]  cnt_q;
    logic [23:0] sh_q;
    logic [7:0]  op_q;
    logic [7:0]  obuf_q;
    logic [2:0]  ocnt_q;
    logic [23:0] addr_q;
    logic        wlatch_q, varm_q, nvbusy_q;
    logic [15:0] st_q, nv_q, pend_q;
    logic [$clog2(WRITE_CYCLES+1)-1:0] wcnt_q;
    logic        rise, fall, cs_rise, busy, dual, wr_ok, wr_vol, wr_nv;
    logic [7:0]  op_now, obyte;
    logic [15:0] wr_data, wr_mask, vol_next, nv_next;

    assign rise    = pins_i.sclk & ~sclk_q & ~pins_i.cs_n;
    assign fall    = ~pins_i.sclk & sclk_q & ~pins_i.cs_n;
    assign cs_rise = pins_i.cs_n & ~cs_n_q;
    assign busy    = nvbusy_q | ext_busy_i;
    assign op_now  = {sh_q[6:0], pins_i.si};
    assign dual    = (op_q == OP_DUAL);

    assign status_register_low_o  = {st_q[7:2], wlatch_q, busy};
    assign status_register_high_o = {suspend_flag_i, st_q[14:8]};
    assign nv_status_o = nv_q;
    assign mem_addr_o  = addr_q;

    // data bytes arrive register 1 first; 31h carries register 2 only
    always_comb begin
        wr_data = 16'h0000;
        wr_mask = 16'h0000;
        wr_ok   = 1'b0;
        if (op_q == OP_WRSR2 && cnt_q == OPCODE_BITS) begin
            wr_data = {sh_q[7:0], 8'h00};
            wr_mask = SR2_WR_MASK;
            wr_ok   = 1'b1;
        end else if (op_q == OP_WRSR1 && cnt_q == OPCODE_BITS) begin
            wr_data = {8'h00, sh_q[7:0]};
            wr_mask = SR1_WR_MASK;
            wr_ok   = 1'b1;
        end else if (op_q == OP_WRSR1 && cnt_q == WORD_BITS) begin
            wr_data = {sh_q[7:0], sh_q[15:8]};
            wr_mask = SR1_WR_MASK | SR2_WR_MASK;
            wr_ok   = 1'b1;
        end
        wr_data = wr_data & wr_mask;
        vol_next = (st_q & ~wr_mask) | wr_data;
        // a volatile write may still set these lock bits, never clear them
        vol_next[BIT_STLOCK] = vol_next[BIT_STLOCK] | st_q[BIT_STLOCK];
        vol_next[BIT_LOCK3:BIT_LOCK0+1] = vol_next[BIT_LOCK3:BIT_LOCK0+1]
                                          | st_q[BIT_LOCK3:BIT_LOCK0+1];
        nv_next = (nv_q & ~wr_mask) | wr_data;
        nv_next[BIT_LOCK3:BIT_LOCK0] = nv_next[BIT_LOCK3:BIT_LOCK0]
                                       | nv_q[BIT_LOCK3:BIT_LOCK0];
    end

    assign wr_nv  = cs_rise && state_q == ST_WRSR && wr_ok && wlatch_q && !busy;
    assign wr_vol = cs_rise && state_q == ST_WRSR && wr_ok && !wlatch_q && varm_q && !busy;

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= pins_i.sclk;
            cs_n_q <= pins_i.cs_n;
        end
    end

    // instruction phases
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || pins_i.cs_n) begin
            state_q <= ST_CMD;
            cnt_q   <= 5'h00;
            sh_q    <= 24'h00_0000;
            op_q    <= 8'h00;
        end else if (rise) begin
            sh_q <= {sh_q[22:0], pins_i.si};
            cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
            unique case (state_q)
                ST_CMD: begin
                    if (cnt_q == OPCODE_BITS - 5'h01) begin
                        op_q  <= op_now;
                        cnt_q <= 5'h00;
                        unique case (op_now)
                            OP_WREN, OP_VWREN, OP_WRDI: state_q <= ST_DONE;
                            OP_RDSR1, OP_RDSR2:         state_q <= ST_STAT;
                            OP_WRSR1, OP_WRSR2:         state_q <= ST_WRSR;
                            OP_READ, OP_FAST, OP_DUAL:
                                state_q <= busy ? ST_IGN : ST_ADDR;
                            default:                    state_q <= ST_IGN;
                        endcase
                    end
                end
                ST_DONE: state_q <= ST_IGN;
                ST_ADDR: begin
                    if (cnt_q == ADDR_BITS - 5'h01) begin
                        cnt_q   <= 5'h00;
                        state_q <= (op_q == OP_READ) ? ST_DATA : ST_DUMY;
                    end
                end
                ST_DUMY: begin
                    if (cnt_q == DUMMY_BITS - 5'h01) begin
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA, ST_STAT, ST_WRSR, ST_IGN: ;
            endcase
        end
    end

    // address counter: loaded from the last address bit, bumped per byte sent
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            addr_q <= 24'h00_0000;
        end else if (rise && state_q == ST_ADDR && cnt_q == ADDR_BITS - 5'h01) begin
            addr_q <= {sh_q[22:0], pins_i.si};
        end else if (fall && state_q == ST_DATA && ocnt_q == 3'h0) begin
            addr_q <= addr_q + 24'h00_0001;
        end
    end

    assign obyte = (state_q == ST_STAT) ?
                   ((op_q == OP_RDSR1) ? status_register_low_o : status_register_high_o)
                   : mem_data_i;

    // output shifter, changes on falling serial clock edges, cleared on deselect
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || pins_i.cs_n) begin
            obuf_q <= 8'h00;
            ocnt_q <= 3'h0;
            pins_o <= '0;
        end else if (fall && (state_q == ST_DATA || state_q == ST_STAT)) begin
            if (state_q == ST_DATA && dual) begin
                if (ocnt_q == 3'h0) begin
                    pins_o.second_io_line <= mem_data_i[7];
                    pins_o.first_io_line  <= mem_data_i[6];
                    obuf_q                <= {mem_data_i[5:0], 2'b00};
                end else begin
                    pins_o.second_io_line <= obuf_q[7];
                    pins_o.first_io_line  <= obuf_q[6];
                    obuf_q                <= {obuf_q[5:0], 2'b00};
                end
                // host has let go of line one by now
                pins_o.first_io_line_oe <= 1'b1;
                ocnt_q                  <= (ocnt_q == 3'h3) ? 3'h0 : ocnt_q + 3'h1;
            end else begin
                if (ocnt_q == 3'h0) begin
                    pins_o.second_io_line <= obyte[7];
                    obuf_q                <= {obyte[6:0], 1'b0};
                end else begin
                    pins_o.second_io_line <= obuf_q[7];
                    obuf_q                <= {obuf_q[6:0], 1'b0};
                end
                ocnt_q <= ocnt_q + 3'h1;
            end
            pins_o.second_io_line_oe <= 1'b1;
        end
    end

    // write enable latch and volatile arm
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            wlatch_q <= 1'b0;
            varm_q   <= 1'b0;
        end else begin
            if (cs_rise && state_q == ST_DONE && !busy) begin
                unique case (op_q)
                    OP_WREN:  wlatch_q <= 1'b1;
                    OP_VWREN: varm_q   <= 1'b1;
                    OP_WRDI: begin
                        wlatch_q <= 1'b0;
                        varm_q   <= 1'b0;
                    end
                    default: ;
                endcase
            end
            if (cs_rise && state_q == ST_WRSR) begin
                varm_q <= 1'b0;
            end
            if (latch_clear_i || (nvbusy_q && wcnt_q == '0)) begin
                wlatch_q <= 1'b0;
            end
        end
    end

    // status copies and the self-timed stored write
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            nv_q     <= nv_status_i & (SR1_WR_MASK | SR2_WR_MASK);
            st_q     <= nv_status_i & (SR1_WR_MASK | SR2_WR_MASK);
            pend_q   <= 16'h0000;
            nvbusy_q <= 1'b0;
            wcnt_q   <= '0;
        end else if (wr_nv) begin
            pend_q   <= nv_next;
            nvbusy_q <= 1'b1;
            wcnt_q   <= ($bits(wcnt_q))'(WRITE_CYCLES - 1);
        end else if (wr_vol) begin
            st_q <= vol_next;
        end else if (nvbusy_q) begin
            if (wcnt_q == '0) begin
                nv_q     <= pend_q;
                st_q     <= pend_q;
                nvbusy_q <= 1'b0;
            end else begin
                wcnt_q <= wcnt_q - 1'b1;
            end
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // a clear in the same cycle legally wins over the enable
    sequence wren_frame_s;
        cs_rise && state_q == ST_DONE && op_q == OP_WREN && !busy && !latch_clear_i;
    endsequence
    sequence nv_start_s;
        wr_nv;
    endsequence

    wren_sets_a: assert property (wren_frame_s |=> wlatch_q)
        else $error("write enable did not set latch");
    vwren_arm_a: assert property (
        cs_rise && state_q == ST_DONE && op_q == OP_VWREN && !busy && !latch_clear_i
        |=> varm_q && wlatch_q == $past(wlatch_q))
        else $error("volatile enable wrong");
    wrdi_clear_a: assert property (
        cs_rise && state_q == ST_DONE && op_q == OP_WRDI && !busy |=> !wlatch_q && !varm_q)
        else $error("write disable did not clear");
    nv_busy_a: assert property (nv_start_s |=> status_register_low_o[BIT_BUSY] [*8])
        else $error("busy not held during stored write");
    lock_kept_a: assert property (
        $past(nrst_i) |->
        (($past(nv_q[BIT_LOCK3:BIT_LOCK0]) & ~nv_q[BIT_LOCK3:BIT_LOCK0]) == 4'h0))
        else $error("security lock bit cleared");
    vol_nobusy_a: assert property (wr_vol && !ext_busy_i |=> !nvbusy_q && !wlatch_q)
        else $error("volatile write raised busy");
    bad_len_a: assert property (
        cs_rise && state_q == ST_WRSR && !wr_ok && !busy |=> st_q == $past(st_q) && !nvbusy_q)
        else $error("bad length status write executed");
    read_busy_a: assert property (
        state_q == ST_CMD && rise && cnt_q == 5'h07 && op_now == OP_READ && busy
        |=> state_q == ST_IGN)
        else $error("read accepted while busy");
    dual_map_a: assert property (
        fall && state_q == ST_DATA && dual && ocnt_q == 3'h0
        |=> pins_o.second_io_line == $past(mem_data_i[7])
            && pins_o.first_io_line == $past(mem_data_i[6]))
        else $error("dual bit order wrong");
    addr_inc_a: assert property (
        fall && state_q == ST_DATA && ocnt_q == 3'h0
        |=> addr_q == $past(addr_q) + 24'h00_0001)
        else $error("address not incremented");
    deselect_a: assert property (
        pins_i.cs_n |=> !pins_o.second_io_line_oe && !pins_o.first_io_line_oe
            && state_q == ST_CMD)
        else $error("outputs driven after deselect");
endmodule : sfc_core

// File: tb/sfc_host_model.sv
/*
 * sfc_host_model: behavioural spi host, mode 0, serial clock a sixth of clk_sys_i.
 * assumes the caller hands whole instructions and counts of output clocks.
 */
`timescale 1ns/1ps
module sfc_host_model (
    input  wire logic                  clk_sys_i,
    input  wire sfc_pkg::sfc_pins_out_t dev_i,
    output sfc_pkg::sfc_pins_in_t       pins_o
);
    import sfc_pkg::*;
    logic cs_n_q  = 1'b1;
    logic sclk_q  = 1'b0;
    logic si_q    = 1'b0;
    logic drive_q = 1'b1;
    // a line released by both ends shows the inverse of the last bit, never a stale copy
    assign pins_o = '{cs_n: cs_n_q, sclk: sclk_q,
                      si: drive_q ? si_q
                                  : (dev_i.first_io_line_oe ? dev_i.first_io_line : ~si_q)};
    task automatic half(input logic lvl);
        sclk_q <= lvl;
        repeat (3) @(posedge clk_sys_i);
    endtask : half
    task automatic frame(input logic [39:0] bits, input int nb, input int nrx,
                         input logic dual, output logic [63:0] rx);
        rx = '0;
        cs_n_q <= 1'b0;
        half(1'b0);
        for (int i = nb - 1; i >= 0; i--) begin
            si_q <= bits[i];
            half(1'b0);
            half(1'b1);
        end
        drive_q <= 1'b0;
        for (int j = 0; j < nrx; j++) begin
            half(1'b0);
            #1;
            rx = dual ? {rx[61:0], dev_i.second_io_line, dev_i.first_io_line}
                      : {rx[62:0], dev_i.second_io_line};
            half(1'b1);
        end
        // clock parks low in the same step as deselect, so no fall is seen
        cs_n_q  <= 1'b1;
        sclk_q  <= 1'b0;
        drive_q <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask : frame
endmodule : sfc_host_model

// File: tb/test_serial_flash_status_and_read_cmds.sv
/*
 * test_serial_flash_status_and_read_cmds: self-checking bench for sfc_core.
 * assumes sfc_host_model as host and a computed array pattern on mem_data_i.
 */
`timescale 1ns/1ps
module test_serial_flash_status_and_read_cmds;
    import sfc_pkg::*;
    localparam int WCYC = 400;
    // stored write keeps the four security lock bits; volatile keeps status lock
    // and the upper three security lock bits
    localparam logic [15:0] NV_KEEP  = 16'h3C00;
    localparam logic [15:0] VOL_KEEP = 16'h3900;
    logic          clk_sys_i      = 1'b0;
    logic          nrst_i         = 1'b0;
    logic [7:0]    mem_data_i     = 8'h00;
    logic          ext_busy_i     = 1'b0;
    logic          latch_clear_i  = 1'b0;
    logic          suspend_flag_i = 1'b0;
    logic [15:0]   nv_status_i    = 16'h0000;
    sfc_pins_in_t  pins_i;
    sfc_pins_out_t pins_o;
    logic [23:0]   mem_addr_o;
    logic [15:0]   nv_status_o;
    logic [15:0]   st;
    logic [15:0]   nv_exp;
    logic          wlatch, busy, oe_seen;
    logic [7:0]    sr_lo, sr_hi;
    logic [63:0]   rx;
    int            fail_count  = 0;
    int            comparisons = 0;
    int            cycles      = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    sfc_core #(.WRITE_CYCLES(WCYC)) i_dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pins_i(pins_i), .pins_o(pins_o),
        .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i), .ext_busy_i(ext_busy_i),
        .latch_clear_i(latch_clear_i), .suspend_flag_i(suspend_flag_i),
        .nv_status_i(nv_status_i), .nv_status_o(nv_status_o),
        .status_register_low_o(sr_lo), .status_register_high_o(sr_hi)
    );
    sfc_host_model i_host (.clk_sys_i(clk_sys_i), .dev_i(pins_o), .pins_o(pins_i));

    function automatic logic [7:0] mb(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
    endfunction : mb
    // lock bits once set stay set; which ones depends on the kind of write
    function automatic logic [15:0] wr(input logic [15:0] old, d, m, keep);
        return (old & ~m) | (d & m) | (old & keep);
    endfunction : wr

    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk_sys_i) begin
        mem_data_i <= mb(mem_addr_o);
        cycles++;
        if (pins_o.second_io_line_oe === 1'b1 || pins_o.first_io_line_oe === 1'b1) begin
            oe_seen = 1'b1;
        end
        if (cycles == 40000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] op);
        i_host.frame(40'(op), 8, 0, 1'b0, rx);
    endtask : cmd
    // sixteen output clocks, so the second byte shows the repeat
    task automatic rd_chk();
        i_host.frame(40'(OP_RDSR1), 8, 16, 1'b0, rx);
        chk(rx[15:0], {2{st[7:2], wlatch, busy}});
        i_host.frame(40'(OP_RDSR2), 8, 16, 1'b0, rx);
        chk(rx[15:0], {2{suspend_flag_i, st[14:8]}});
        chk({sr_hi, sr_lo}, {suspend_flag_i, st[14:2], wlatch, busy});
    endtask : rd_chk

    initial begin
        logic [15:0] d;
        logic [23:0] a;
        logic [7:0]  op;
        d = 16'($urandom(38309));
        nv_status_i    = 16'($urandom());
        suspend_flag_i = 1'($urandom());
        st   = nv_status_i & 16'h7FFC;
        wlatch = 1'b0;
        busy   = 1'b0;
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_chk();
        cmd(OP_WREN);
        wlatch = 1'b1;
        rd_chk();
        d = 16'($urandom());
        i_host.frame(40'({OP_WRSR1, d[11:0]}), 20, 0, 1'b0, rx);
        rd_chk();
        i_host.frame(40'({OP_WRSR1, d[7:0]}), 16, 0, 1'b0, rx);
        busy = 1'b1;
        rd_chk();
        repeat (WCYC) @(posedge clk_sys_i);
        st     = wr(st, d, SR1_WR_MASK, NV_KEEP);
        wlatch = 1'b0;
        busy = 1'b0;
        rd_chk();
        chk(nv_status_o, st);
        i_host.frame(40'({OP_WRSR1, d[15:8], d[7:0]}), 24, 0, 1'b0, rx);
        rd_chk();
        nv_exp = st;
        for (int k = 0; k < 2; k++) begin
            cmd(OP_VWREN);
            rd_chk();
            d = (k == 0) ? 16'($urandom()) : ~d;
            i_host.frame(40'({OP_WRSR1, d[7:0], d[15:8]}), 24, 0, 1'b0, rx);
            st = wr(st, d, SR1_WR_MASK | SR2_WR_MASK, VOL_KEEP);
            rd_chk();
            chk(nv_status_o, nv_exp);
        end
        // register two alone through its own opcode, eight data bits
        cmd(OP_VWREN);
        i_host.frame(40'({OP_WRSR2, ~d[15:8]}), 16, 0, 1'b0, rx);
        st = wr(st, {~d[15:8], 8'h00}, SR2_WR_MASK, VOL_KEEP);
        rd_chk();
        chk(nv_status_o, nv_exp);
        cmd(OP_WREN);
        cmd(OP_VWREN);
        cmd(OP_WRDI);
        i_host.frame(40'({OP_WRSR1, ~d[7:0], ~d[15:8]}), 24, 0, 1'b0, rx);
        rd_chk();
        cmd(OP_WREN);
        @(posedge clk_sys_i);
        latch_clear_i <= 1'b1;
        @(posedge clk_sys_i);
        latch_clear_i <= 1'b0;
        rd_chk();
        i_host.frame(40'(OP_WREN >> 1), 7, 0, 1'b0, rx);
        i_host.frame(40'({OP_WREN, 1'b0}), 9, 0, 1'b0, rx);
        rd_chk();
        for (int k = 0; k < 6; k++) begin
            op = (k % 3 == 0) ? OP_READ : (k % 3 == 1) ? OP_FAST : OP_DUAL;
            a  = (k < 3) ? 24'hFF_FFFE : 24'($urandom());
            i_host.frame((op == OP_READ) ? 40'({op, a}) : {op, a, 8'h00},
                         (op == OP_READ) ? 32 : 40, (op == OP_DUAL) ? 8 : 16,
                         op == OP_DUAL, rx);
            chk(rx[15:0], {mb(a), mb(a + 24'h00_0001)});
        end
        ext_busy_i <= 1'b1;
        busy    = 1'b1;
        oe_seen = 1'b0;
        i_host.frame(40'({OP_READ, 24'($urandom())}), 32, 16, 1'b0, rx);
        chk(16'(oe_seen), 16'h0000);
        rd_chk();
        ext_busy_i <= 1'b0;
        stop_test();
    end
endmodule : test_serial_flash_status_and_read_cmds
